// File: pkg/dma_irq_params.svh
`ifndef DMA_IRQ_PARAMS_SVH
`define DMA_IRQ_PARAMS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_ENABLE_MASK_LOW    8'h00
`define OFS_ENABLE_MASK_HIGH   8'h04
`define OFS_ENABLE_CLEAR_LOW   8'h08
`define OFS_ENABLE_CLEAR_HIGH  8'h0C
`define OFS_ENABLE_SET_LOW     8'h10
`define OFS_ENABLE_SET_HIGH    8'h14
`define OFS_PENDING_LOW        8'h18
`define OFS_PENDING_HIGH       8'h1C
`define OFS_PENDING_CLEAR_LOW  8'h20
`define OFS_PENDING_CLEAR_HIGH 8'h24
`define OFS_IRQ_REEVALUATE     8'h28
`define OFS_IRQ_STATUS         8'h2C
`define OFS_IRQ_MASK           8'h30

// ****************************************************************
// fields and reset values
// ****************************************************************
`define REEVALUATE_BIT         0
`define STATUS_COMPLETION_BIT  0
`define STATUS_DROPPED_BIT     1
`define STATUS_WIDTH           2
`define CODE_HIGH_BIT          5
`define WORD_RESET             32'h00000000
`define STATUS_RESET           2'h0
`define WORD_ZERO              32'h00000000

`endif

// File: pkg/dma_irq_pkg.sv
package dma_irq_pkg;
  typedef logic [31:0] word_type;
  typedef logic [5:0]  code_type;
  typedef logic [63:0] code_vec_type;

  typedef enum logic [3:0] {
    sel_none,
    sel_enable_mask_low,
    sel_enable_mask_high,
    sel_enable_clear_low,
    sel_enable_clear_high,
    sel_enable_set_low,
    sel_enable_set_high,
    sel_pending_low,
    sel_pending_high,
    sel_pending_clear_low,
    sel_pending_clear_high,
    sel_irq_reevaluate,
    sel_irq_status,
    sel_irq_mask
  } reg_sel_type;

  typedef enum logic {
    bus_idle,
    bus_read_done
  } bus_state_type;
endpackage

// File: pkg/irq_bank_if.sv
`timescale 1ns/1ps
`default_nettype none
interface irq_bank_if;
  import dma_irq_pkg::*;
  word_type set_mask;
  word_type clear_mask;
  word_type pending_clear;
  word_type code_hit;
  word_type enable_mask;
  word_type pending;

  modport bank (
    input  set_mask,
    input  clear_mask,
    input  pending_clear,
    input  code_hit,
    output enable_mask,
    output pending
  );
  modport ctrl (
    output set_mask,
    output clear_mask,
    output pending_clear,
    output code_hit,
    input  enable_mask,
    input  pending
  );
endinterface
`default_nettype wire

// File: logic/irq_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_irq_params.svh"
module irq_bank (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  irq_bank_if.bank  bank
);
  import dma_irq_pkg::*;

  // enable mask only moves through the set and clear strobes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank.enable_mask <= `WORD_RESET;
    end else begin
      bank.enable_mask <= (bank.enable_mask | bank.set_mask) & ~bank.clear_mask; // RULE1 RULE2 RULE3 RULE11
    end
  end

  // set wins over clear so a code landing with its clear is kept
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank.pending <= `WORD_RESET; // RULE10
    end else begin
      bank.pending <= (bank.pending & ~bank.pending_clear) | bank.code_hit; // RULE6 RULE7 RULE8
    end
  end
endmodule
`default_nettype wire

// File: logic/irq_pulse_gen.sv
`timescale 1ns/1ps
`default_nettype none
module irq_pulse_gen (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire dma_irq_pkg::code_vec_type  enabled_pending_i,
  input  wire logic                       reevaluate_i,
  output logic                            pulse_o
);
  import dma_irq_pkg::*;

  logic any_now;
  logic any_before;

  assign any_now = |enabled_pending_i; // RULE12 RULE14

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      any_before <= 1'b0;
    end else begin
      any_before <= any_now;
    end
  end

  // a new edge only after the whole enabled pending set drained to zero; reevaluate pulses without one
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= (any_now & ~any_before) | (reevaluate_i & any_now); // RULE9 RULE13 RULE14
    end
  end
endmodule
`default_nettype wire

// File: logic/dma_completion_irq_logic.sv
// Summary of operation
// (RULE1) a one in enable_clear_high bit n clears enable of code 32+n
// (RULE2) a one in enable_set_low bit n sets enable of code n
// (RULE3) a one in enable_set_high bit n sets enable of code 32+n
// (RULE4) codes are returned only when final or intermediate irq enable is set
// (RULE5) returned code equals the option word completion_code field
// (RULE6) code n sets pending_low bit n or pending_high bit n-32
// (RULE7) pending bits are sticky until software clears them
// (RULE8) a one in the pending clear pair clears that pending bit
// (RULE9) no further interrupt until all pending bits have been cleared; the code re-arms once all enabled pending bits are zero
// (RULE10) pending registers are read-only and reset to zero
// (RULE11) enable masks are read-only; only set and clear change them
// (RULE12) each enable bit gates its pending code onto the interrupt
// (RULE13) writing one to the reevaluate bit pulses if enabled pending remains
// (RULE14) interrupt pulses when pending and enable together leave all-clear
// (RULE15) enable set and clear registers read back as zero
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dma_irq_params.svh"
module dma_completion_irq_logic (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // avalon-mm slave
  input  wire logic [7:0]            avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [3:0]            avs_byteenable_i,
  input  wire dma_irq_pkg::word_type avs_writedata_i,
  output dma_irq_pkg::word_type      avs_readdata_o,
  output logic                       avs_waitrequest_o,
  // normal completion from the transfer engines
  input  wire logic                  engine_valid_i,
  input  wire dma_irq_pkg::code_type engine_completion_code_i,
  input  wire logic                  engine_final_completion_irq_en_i,
  input  wire logic                  engine_intermediate_completion_irq_en_i,
  // early completion from the channel controller itself
  input  wire logic                  early_valid_i,
  input  wire dma_irq_pkg::code_type early_completion_code_i,
  input  wire logic                  early_final_completion_irq_en_i,
  input  wire logic                  early_intermediate_completion_irq_en_i,
  // interrupts
  output logic                       completion_irq_o,
  output logic                       irq_o
);
  import dma_irq_pkg::*;

  // ****************************************************************
  // address decode
  // ****************************************************************
  reg_sel_type sel;

  always_comb begin
    if (avs_address_i == `OFS_ENABLE_MASK_LOW) begin
      sel = sel_enable_mask_low;
    end else if (avs_address_i == `OFS_ENABLE_MASK_HIGH) begin
      sel = sel_enable_mask_high;
    end else if (avs_address_i == `OFS_ENABLE_CLEAR_LOW) begin
      sel = sel_enable_clear_low;
    end else if (avs_address_i == `OFS_ENABLE_CLEAR_HIGH) begin
      sel = sel_enable_clear_high;
    end else if (avs_address_i == `OFS_ENABLE_SET_LOW) begin
      sel = sel_enable_set_low;
    end else if (avs_address_i == `OFS_ENABLE_SET_HIGH) begin
      sel = sel_enable_set_high;
    end else if (avs_address_i == `OFS_PENDING_LOW) begin
      sel = sel_pending_low;
    end else if (avs_address_i == `OFS_PENDING_HIGH) begin
      sel = sel_pending_high;
    end else if (avs_address_i == `OFS_PENDING_CLEAR_LOW) begin
      sel = sel_pending_clear_low;
    end else if (avs_address_i == `OFS_PENDING_CLEAR_HIGH) begin
      sel = sel_pending_clear_high;
    end else if (avs_address_i == `OFS_IRQ_REEVALUATE) begin
      sel = sel_irq_reevaluate;
    end else if (avs_address_i == `OFS_IRQ_STATUS) begin
      sel = sel_irq_status;
    end else if (avs_address_i == `OFS_IRQ_MASK) begin
      sel = sel_irq_mask;
    end else begin
      sel = sel_none;
    end
  end

  // ****************************************************************
  // write strobes
  // ****************************************************************
  word_type wmask;
  word_type wbits;

  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  // writes finish in their first cycle, so no double strobe
  assign wbits = avs_write_i ? (avs_writedata_i & wmask) : `WORD_ZERO;

  irq_bank_if low_if ();
  irq_bank_if high_if ();

  assign low_if.set_mask       = (sel == sel_enable_set_low)     ? wbits : `WORD_ZERO; // RULE2
  assign high_if.set_mask      = (sel == sel_enable_set_high)    ? wbits : `WORD_ZERO; // RULE3
  assign low_if.clear_mask     = (sel == sel_enable_clear_low)   ? wbits : `WORD_ZERO;
  assign high_if.clear_mask    = (sel == sel_enable_clear_high)  ? wbits : `WORD_ZERO; // RULE1
  assign low_if.pending_clear  = (sel == sel_pending_clear_low)  ? wbits : `WORD_ZERO; // RULE8
  assign high_if.pending_clear = (sel == sel_pending_clear_high) ? wbits : `WORD_ZERO; // RULE8

  logic reevaluate;

  assign reevaluate = (sel == sel_irq_reevaluate) & wbits[`REEVALUATE_BIT]; // RULE13

  // ****************************************************************
  // completion code capture
  // ****************************************************************
  logic         engine_take;
  logic         early_take;
  code_vec_type engine_hit;
  code_vec_type early_hit;
  code_vec_type all_hit;
  logic         dropped;

  // a code without either irq enable carries no completion interrupt, only the dropped status bit
  assign engine_take = engine_valid_i &
                       (engine_final_completion_irq_en_i | engine_intermediate_completion_irq_en_i); // RULE4
  assign early_take  = early_valid_i &
                       (early_final_completion_irq_en_i | early_intermediate_completion_irq_en_i); // RULE4
  assign dropped     = (engine_valid_i & ~engine_take) | (early_valid_i & ~early_take);

  // code value is the option word field as passed, unaltered
  assign engine_hit = engine_take ? (64'h1 << engine_completion_code_i) : 64'h0; // RULE5 RULE6
  assign early_hit  = early_take ? (64'h1 << early_completion_code_i) : 64'h0;   // RULE5 RULE6
  assign all_hit    = engine_hit | early_hit;

  assign low_if.code_hit  = all_hit[31:0];  // RULE6
  assign high_if.code_hit = all_hit[63:32]; // RULE6

  irq_bank low_bank (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .bank    (low_if)
  );

  irq_bank high_bank (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .bank    (high_if)
  );

  // ****************************************************************
  // completion interrupt
  // ****************************************************************
  code_vec_type enabled_pending;

  assign enabled_pending = {high_if.pending & high_if.enable_mask,
                            low_if.pending & low_if.enable_mask}; // RULE12 RULE14

  irq_pulse_gen pulse_gen (
    .clk_i             (clk_i),
    .rst_n_i           (rst_n_i),
    .enabled_pending_i (enabled_pending),
    .reevaluate_i      (reevaluate),
    .pulse_o           (completion_irq_o)
  );

  // ****************************************************************
  // block status and mask
  // ****************************************************************
  logic [`STATUS_WIDTH-1:0] status;
  logic [`STATUS_WIDTH-1:0] status_mask;
  logic [`STATUS_WIDTH-1:0] status_event;
  logic [`STATUS_WIDTH-1:0] status_clear;

  assign status_event = {dropped, completion_irq_o};
  assign status_clear = (sel == sel_irq_status) ? wbits[`STATUS_WIDTH-1:0] : `STATUS_RESET;

  // event in the clearing cycle survives
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status <= `STATUS_RESET;
    end else begin
      status <= (status & ~status_clear) | status_event;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_mask <= `STATUS_RESET;
    end else if (avs_write_i && sel == sel_irq_mask) begin
      status_mask <= (status_mask & ~wmask[`STATUS_WIDTH-1:0])
                     | (avs_writedata_i[`STATUS_WIDTH-1:0] & wmask[`STATUS_WIDTH-1:0]);
    end
  end

  assign irq_o = |(status & status_mask);

  // ****************************************************************
  // read path
  // ****************************************************************
  bus_state_type bus_state;
  word_type      read_value;

  // one wait cycle lets read data come from a flop
  assign avs_waitrequest_o = avs_read_i & (bus_state == bus_idle);

  always_comb begin
    read_value = `WORD_ZERO;
    case (sel)
      sel_enable_mask_low:  read_value = low_if.enable_mask;
      sel_enable_mask_high: read_value = high_if.enable_mask;
      sel_pending_low:      read_value = low_if.pending;  // RULE10
      sel_pending_high:     read_value = high_if.pending; // RULE10
      sel_irq_status:       read_value = {{(32-`STATUS_WIDTH){1'b0}}, status};
      sel_irq_mask:         read_value = {{(32-`STATUS_WIDTH){1'b0}}, status_mask};
      // write-only and unmapped words read as zero
      default:              read_value = `WORD_ZERO; // RULE15
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_state <= bus_idle;
    end else begin
      case (bus_state)
        bus_idle: begin
          if (avs_read_i) begin
            bus_state <= bus_read_done;
          end
        end
        default: begin
          bus_state <= bus_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= `WORD_RESET;
    end else if (avs_read_i && bus_state == bus_idle) begin
      avs_readdata_o <= read_value;
    end
  end
endmodule
`default_nettype wire

// File: sim/completion_source.sv
`timescale 1ns/1ps
`default_nettype none
module completion_source (
  input  wire logic             clk_i,
  output logic                  valid_o,
  output dma_irq_pkg::code_type code_o,
  output logic                  final_o,
  output logic                  inter_o
);
  import dma_irq_pkg::*;
  initial begin
    valid_o = 1'b0;
    code_o = 6'h00;
    final_o = 1'b0;
    inter_o = 1'b0;
  end
  task automatic send(input code_type c, input logic f, input logic i);
    @(posedge clk_i);
    valid_o <= 1'b1;
    code_o <= c;
    final_o <= f;
    inter_o <= i;
    @(posedge clk_i);
    valid_o <= 1'b0;
    // idle lines carry no stale code
    code_o <= ~c;
    final_o <= ~f;
    inter_o <= ~i;
  endtask
endmodule
`default_nettype wire

// File: sim/dma_completion_irq_logic_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_irq_params.svh"
module dma_completion_irq_logic_assertions (
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire logic [7:0]            avs_address_i,
  input wire logic                  avs_read_i,
  input wire logic                  avs_write_i,
  input wire dma_irq_pkg::word_type avs_readdata_o,
  input wire logic                  avs_waitrequest_o,
  input wire logic                  engine_valid_i,
  input wire logic                  early_valid_i,
  input wire logic                  completion_irq_o,
  input wire logic                  irq_o
);
  import dma_irq_pkg::*;
  logic wo_sel;
  assign wo_sel = avs_address_i inside {8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  write_no_wait_a: assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("write stalled");
  read_one_wait_a: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read wait wrong");
  wo_reads_zero_a: assert property (avs_read_i && !avs_waitrequest_o && wo_sel |-> avs_readdata_o == 32'h0)
    else $error("write-only word read nonzero");
  unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 8'h30
    |-> avs_readdata_o == 32'h0) else $error("unmapped read nonzero");
  reset_quiet_a: assert property ($rose(rst_n_i) |-> !completion_irq_o && !irq_o)
    else $error("irq after reset");
  pulse_cause_a: assert property (completion_irq_o |-> $past(engine_valid_i, 2) ||
    $past(early_valid_i, 2) || $past(avs_write_i, 2) || $past(avs_write_i))
    else $error("pulse without cause");
  irq_rise_cause_a: assert property ($rose(irq_o) |-> $past(completion_irq_o) || $past(engine_valid_i)
    || $past(early_valid_i) || $past(avs_write_i)) else $error("irq rose without cause");
  readdata_hold_a: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("readdata moved");
  cover property (completion_irq_o);
  cover property ($rose(irq_o));
  cover property (avs_read_i && !avs_waitrequest_o);
endmodule
bind dma_completion_irq_logic dma_completion_irq_logic_assertions u_chk (.clk_i, .rst_n_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .engine_valid_i, .early_valid_i,
  .completion_irq_o, .irq_o);
`default_nettype wire

// File: sim/dma_completion_irq_logic_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_irq_params.svh"
module dma_completion_irq_logic_tb_top;
  import dma_irq_pkg::*;
  logic     clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, completion_irq_o, irq_o;
  logic     ev, ef, ei, xv, xf, xi;
  logic [7:0] avs_address_i;
  word_type avs_writedata_i, avs_readdata_o;
  code_type ec, xc;
  int       mismatches, n_tests, pulses;
  dma_completion_irq_logic u_dma_completion_irq_logic (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_byteenable_i(4'hF), .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .engine_valid_i(ev), .engine_completion_code_i(ec), .engine_final_completion_irq_en_i(ef),
    .engine_intermediate_completion_irq_en_i(ei), .early_valid_i(xv), .early_completion_code_i(xc),
    .early_final_completion_irq_en_i(xf), .early_intermediate_completion_irq_en_i(xi),
    .completion_irq_o, .irq_o);
  completion_source u_eng (.clk_i, .valid_o(ev), .code_o(ec), .final_o(ef), .inter_o(ei));
  completion_source u_early (.clk_i, .valid_o(xv), .code_o(xc), .final_o(xf), .inter_o(xi));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(negedge clk_i) if (completion_irq_o === 1'b1) pulses++;
  task automatic test_done;
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input word_type g, input word_type e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // request stands until waitrequest is seen low at a rising edge; only the watchdog ends a hang
  task automatic bus(input logic r, input logic [7:0] a, input word_type d, output word_type q);
    @(posedge clk_i);
    avs_read_i <= r;
    avs_write_i <= !r;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input word_type d);
    word_type q;
    bus(1'b0, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input word_type e);
    word_type q;
    bus(1'b1, a, 32'h00000000, q);
    chk(q, e);
  endtask
  task automatic idle;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic irq_is(input logic e);
    @(negedge clk_i);
    chk({31'h0, irq_o}, {31'h0, e});
  endtask
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    test_done;
  end
  initial begin
    {rst_n_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdc(`OFS_PENDING_LOW, 32'h00000000);
    rdc(`OFS_PENDING_HIGH, 32'h00000000);
    wr(`OFS_ENABLE_SET_LOW, 32'h00000021);
    wr(`OFS_ENABLE_SET_LOW, 32'h00000100);
    rdc(`OFS_ENABLE_MASK_LOW, 32'h00000121);
    rdc(`OFS_ENABLE_SET_LOW, 32'h00000000);
    wr(`OFS_ENABLE_SET_HIGH, 32'h80000003);
    wr(`OFS_ENABLE_CLEAR_HIGH, 32'h00000002);
    wr(`OFS_ENABLE_CLEAR_HIGH, 32'h00000000);
    rdc(`OFS_ENABLE_MASK_HIGH, 32'h80000001);
    rdc(`OFS_ENABLE_CLEAR_HIGH, 32'h00000000);
    wr(`OFS_ENABLE_MASK_LOW, 32'hFFFFFFFF);
    wr(`OFS_PENDING_LOW, 32'hFFFFFFFF);
    rdc(`OFS_ENABLE_MASK_LOW, 32'h00000121);
    rdc(`OFS_PENDING_LOW, 32'h00000000);
    rdc(8'hFC, 32'h00000000);
    u_eng.send(6'd5, 1'b1, 1'b0);
    idle;
    chk(word_type'(pulses), 32'h00000001);
    rdc(`OFS_PENDING_LOW, 32'h00000020);
    u_early.send(6'd63, 1'b0, 1'b1);
    u_eng.send(6'd7, 1'b0, 1'b0);
    u_early.send(6'd33, 1'b1, 1'b1);
    idle;
    chk(word_type'(pulses), 32'h00000001);
    rdc(`OFS_PENDING_HIGH, 32'h80000002);
    rdc(`OFS_PENDING_LOW, 32'h00000020);
    rdc(`OFS_IRQ_STATUS, 32'h00000003);
    irq_is(1'b0);
    wr(`OFS_IRQ_MASK, 32'h00000001);
    irq_is(1'b1);
    wr(`OFS_IRQ_STATUS, 32'h00000001);
    irq_is(1'b0);
    wr(`OFS_PENDING_CLEAR_LOW, 32'h00000000);
    rdc(`OFS_PENDING_LOW, 32'h00000020);
    wr(`OFS_PENDING_CLEAR_LOW, 32'h00000020);
    rdc(`OFS_PENDING_LOW, 32'h00000000);
    rdc(`OFS_PENDING_HIGH, 32'h80000002);
    wr(`OFS_IRQ_REEVALUATE, 32'h00000000);
    idle;
    chk(word_type'(pulses), 32'h00000001);
    wr(`OFS_IRQ_REEVALUATE, 32'h00000001);
    idle;
    chk(word_type'(pulses), 32'h00000002);
    wr(`OFS_PENDING_CLEAR_HIGH, 32'hFFFFFFFF);
    u_early.send(6'd34, 1'b1, 1'b0);
    idle;
    chk(word_type'(pulses), 32'h00000002);
    rdc(`OFS_PENDING_HIGH, 32'h00000004);
    wr(`OFS_PENDING_CLEAR_HIGH, 32'h00000004);
    u_eng.send(6'd5, 1'b1, 1'b0);
    idle;
    chk(word_type'(pulses), 32'h00000003);
    test_done;
  end
endmodule
`default_nettype wire
